// >>> rtl/grb_regs.sv
// Gauge readback bank with resistive ADC retry sequencer on AXI4-Lite
//
// Operation
// - Cell voltage is a 16-bit value of 78.125uV counts up to 5.12V, low byte at 0x63.
// - Time to empty is a read-only pair at 0x64 high and 0x65 low in 5.625s counts.
// - Charge level is a read-only pair at 0x66 high and 0x67 low in 0.00390625% counts.
// - Time to full is a read-only pair at 0x68 high and 0x69 low in 5.625s counts.
// - Validity bits 4..0 flag full time, charge, empty time, voltage, average voltage; reset 0.
// - Validity bit 7 is the read-only debug port ready flag, reset 0.
// - Validity bit 5 is a writable sniffer enable that resets to 1.
// - ADC control bits 6:3 at 0x70 hold the ground threshold, reset 0x4.
// - ADC control bits 2:0 hold the retry count, reset 0x1, zero meaning no retry.
// - Retry when peak is 0xFF at 1uA and average below 0xFF minus clamp, or peak 0xFF otherwise.
// - When retries are used up and the condition still holds the result is Abort.
// - The cell voltage high byte is a read-only register at 0x62 that resets to zero.
//
// Our own choice: the AXI4-Lite register port.
`include "gauge_regs_defs.svh"
module grb_regs
  import grb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] gauge_cell_voltage,
  input  wire logic [15:0] gauge_empty_time,
  input  wire logic [15:0] gauge_charge_level,
  input  wire logic [15:0] gauge_full_time,
  input  wire logic        gauge_load,
  input  wire logic [4:0]  gauge_reliable,
  input  wire logic        debug_port_ready,
  input  wire logic        adc_done,
  input  wire logic [7:0]  adc_peak,
  input  wire logic [7:0]  adc_average,
  input  wire logic        adc_pullup_1ua,
  input  wire logic [5:0]  noise_clamp_margin,
  output logic             adc_start,
  output logic [3:0]       adc_ground_threshold,
  output logic             sniffer_enable,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] awaddr;
    logic        aw_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_held;
    logic [15:0] cell_voltage;
    logic [15:0] empty_time;
    logic [15:0] charge_level;
    logic [15:0] full_time;
    logic [4:0]  reliable;
    logic        dbg_meta;
    logic        dbg_sync;
    logic        sniff_en;
    logic [3:0]  gnd_thr;
    logic [2:0]  rty_cnt;
    grb_meas_t   meas;
    logic [2:0]  rty_used;
    grb_result_t result;
    logic        start;
    logic        pk;
    logic        pu1;
    logic [7:0]  av;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
  } grb_state_t;

  grb_state_t s_q;
  grb_state_t s_d;

  logic        retry_cond;
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_byte;
  logic [2:0]  ev;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic        wr_ok;

  //////////////////////////////////////////////////////////////////////////
  // Word-per-register map: the byte offset is the register number times four
  always_comb begin
    rd_idx  = s_axi_araddr[9:2];
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    unique case (rd_idx)
      `GRB_OFF_VCELL_HI:  rd_byte = s_q.cell_voltage[15:8];
      `GRB_OFF_VCELL_LO:  rd_byte = s_q.cell_voltage[7:0];
      `GRB_OFF_EMPTY_HI:  rd_byte = s_q.empty_time[15:8];
      `GRB_OFF_EMPTY_LO:  rd_byte = s_q.empty_time[7:0];
      `GRB_OFF_CHARGE_HI: rd_byte = s_q.charge_level[15:8];
      `GRB_OFF_CHARGE_LO: rd_byte = s_q.charge_level[7:0];
      `GRB_OFF_FULL_HI:   rd_byte = s_q.full_time[15:8];
      `GRB_OFF_FULL_LO:   rd_byte = s_q.full_time[7:0];
      `GRB_OFF_VALID:     rd_byte = {s_q.dbg_sync, 1'b0, s_q.sniff_en,
                                     s_q.reliable};
      `GRB_OFF_ADC_CTRL:  rd_byte = {1'b0, s_q.gnd_thr, s_q.rty_cnt};
      `GRB_OFF_IRQ_STAT:  rd_byte = {5'h00, s_q.irq_stat};
      `GRB_OFF_IRQ_MASK:  rd_byte = {5'h00, s_q.irq_mask};
      `GRB_OFF_MEAS_STAT: rd_byte = {s_q.meas != GRB_M_IDLE, 1'b0,
                                     s_q.result, 1'b0, s_q.rty_used};
      `GRB_OFF_MEAS_CMD:  rd_byte = 8'h00;
      default:            rd_ok   = 1'b0;
    endcase
  end

  // Retry test: a clamped peak, judged on the latched sample
  assign retry_cond = s_q.pk &&
    (!s_q.pu1 || (s_q.av < (`GRB_ADC_FULL - {2'b00, noise_clamp_margin})));

  always_comb begin
    s_d = s_q;
    ev  = 3'b000;
    s_d.start = 1'b0;
    // Double flop for the debug port ready level from outside
    s_d.dbg_meta = debug_port_ready;
    s_d.dbg_sync = s_q.dbg_meta;
    // The whole snapshot lands on one edge, so no pair is ever torn
    if (gauge_load) begin
      s_d.cell_voltage = gauge_cell_voltage;
      s_d.empty_time   = gauge_empty_time;
      s_d.charge_level = gauge_charge_level;
      s_d.full_time    = gauge_full_time;
      s_d.reliable     = gauge_reliable;
    end

    // Write channel: address and data taken independently, in any order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr  = s_axi_awaddr;
      s_d.aw_held = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
      s_d.w_held = 1'b1;
      s_d.wready = 1'b0;
    end
    wr_go   = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    wr_idx  = s_q.awaddr[9:2];
    wr_byte = s_q.wdata[7:0];
    wr_ok   = 1'b1;
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      unique case (wr_idx)
        `GRB_OFF_VALID: begin
          if (s_q.wstrb[0])
            s_d.sniff_en = wr_byte[`GRB_BIT_SNIFF_EN];
        end
        `GRB_OFF_ADC_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.gnd_thr = wr_byte[`GRB_THR_MSB:`GRB_THR_LSB];
            s_d.rty_cnt = wr_byte[`GRB_RTY_MSB:`GRB_RTY_LSB];
          end
        end
        `GRB_OFF_IRQ_MASK: begin
          if (s_q.wstrb[0])
            s_d.irq_mask = wr_byte[2:0];
        end
        `GRB_OFF_MEAS_CMD: begin
          // A start while busy is ignored so retries are never cut short
          if (s_q.wstrb[0] && wr_byte[0] && s_q.meas == GRB_M_IDLE) begin
            s_d.meas     = GRB_M_WAIT;
            s_d.rty_used = 3'h0;
            s_d.result   = GRB_R_NONE;
            s_d.start    = 1'b1;
          end
        end
        `GRB_OFF_IRQ_STAT, `GRB_OFF_VCELL_HI, `GRB_OFF_VCELL_LO,
        `GRB_OFF_EMPTY_HI, `GRB_OFF_EMPTY_LO, `GRB_OFF_CHARGE_HI,
        `GRB_OFF_CHARGE_LO, `GRB_OFF_FULL_HI, `GRB_OFF_FULL_LO,
        `GRB_OFF_MEAS_STAT: ;
        default: wr_ok = 1'b0;
      endcase
      s_d.bresp = wr_ok ? 2'b00 : 2'b10;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // Read channel: the word is frozen at the address handshake, so a gauge
    // load while rvalid waits cannot tear the byte the host receives
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = {24'h000000, rd_byte};
      s_d.rresp   = rd_ok ? 2'b00 : 2'b10;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // Measurement sequencer
    unique case (s_q.meas)
      GRB_M_IDLE: ;
      GRB_M_WAIT: begin
        if (adc_done) begin
          s_d.pk   = (adc_peak == `GRB_ADC_FULL);
          s_d.pu1  = adc_pullup_1ua;
          s_d.av   = adc_average;
          s_d.meas = GRB_M_JUDGE;
        end
      end
      GRB_M_JUDGE: begin
        // Every try is judged on its own latched sample; of the live pins only noise_clamp_margin is read
        if (!retry_cond) begin
          s_d.result = GRB_R_GOOD;
          s_d.meas   = GRB_M_IDLE;
          ev[`GRB_IRQ_DONE] = 1'b1;
        end else if (s_q.rty_used < s_q.rty_cnt) begin
          s_d.rty_used = s_q.rty_used + 3'h1;
          s_d.start    = 1'b1;
          s_d.meas     = GRB_M_WAIT;
          ev[`GRB_IRQ_RETRY] = 1'b1;
        end else begin
          s_d.result = GRB_R_ABORT;
          s_d.meas   = GRB_M_IDLE;
          ev[`GRB_IRQ_ABORT] = 1'b1;
        end
      end
    endcase

    // Sticky status: a new event wins over a write-one clear
    if (wr_go && wr_idx == `GRB_OFF_IRQ_STAT && s_q.wstrb[0])
      s_d.irq_stat = s_q.irq_stat & ~wr_byte[2:0];
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_q.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.awready  <= 1'b1;
      s_q.wready   <= 1'b1;
      s_q.arready  <= 1'b1;
      s_q.sniff_en <= 1'b1;
      s_q.gnd_thr  <= `GRB_THR_RST;
      s_q.rty_cnt  <= `GRB_RTY_RST;
      s_q.meas     <= GRB_M_IDLE;
      s_q.result   <= GRB_R_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready        = s_q.awready;
  assign s_axi_wready         = s_q.wready;
  assign s_axi_bvalid         = s_q.bvalid;
  assign s_axi_bresp          = s_q.bresp;
  assign s_axi_arready        = s_q.arready;
  assign s_axi_rvalid         = s_q.rvalid;
  assign s_axi_rresp          = s_q.rresp;
  assign s_axi_rdata          = s_q.rdata;
  assign adc_start            = s_q.start;
  assign adc_ground_threshold = s_q.gnd_thr;
  assign sniffer_enable       = s_q.sniff_en;
  assign irq                  = s_q.irq;

  //////////////////////////////////////////////////////////////////////////
  AST_ABORT_ONLY_AT_LIMIT: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_q.meas == GRB_M_JUDGE && retry_cond && s_q.rty_used >= s_q.rty_cnt)
    |=> (s_q.result == GRB_R_ABORT && s_q.meas == GRB_M_IDLE))
    else $error("abort not reported after last retry");
  AST_RETRY_RESTARTS: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_q.meas == GRB_M_JUDGE && retry_cond && s_q.rty_used < s_q.rty_cnt)
    |=> (adc_start && s_q.meas == GRB_M_WAIT))
    else $error("retry did not restart the measurement");
  AST_NO_RETRY_CLEAN: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_q.meas == GRB_M_JUDGE && !retry_cond)
    |=> s_q.result == GRB_R_GOOD)
    else $error("clean reading not reported good");
  AST_RETRIES_BOUNDED: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_q.meas != GRB_M_IDLE |-> s_q.rty_used <= s_q.rty_cnt)
    else $error("retry count exceeded");
  AST_SNIFF_RESET: assert property (@(posedge aclk)
    $rose(aresetn) |-> sniffer_enable && adc_ground_threshold == 4'h4)
    else $error("wrong reset value in control bits");
  AST_PAIR_ORDER: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $rose(gauge_load) ##0 !$past(gauge_load) |=>
      s_q.empty_time == $past(gauge_empty_time))
    else $error("byte pair not loaded from gauge value");
  AST_READY_SYNC: assert property (@(posedge aclk)
    disable iff (!aresetn)
    debug_port_ready [*3] |-> s_q.dbg_sync)
    else $error("debug ready flag did not follow");
  AST_READ_ANSWER: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_IRQ_LEVEL: assert property (@(posedge aclk)
    disable iff (!aresetn)
    irq |-> |($past(s_d.irq_stat) & $past(s_q.irq_mask)))
    else $error("interrupt without unmasked status");

  // Sequencer pulse shape, sticky status, read-only hold, reset values, write response and ready sync
  AST_START_PULSE: assert property (@(posedge aclk)
    disable iff (!aresetn)
    adc_start |=> !adc_start)
    else $error("measurement start held longer than one cycle");
  AST_START_ONLY_WAIT: assert property (@(posedge aclk)
    disable iff (!aresetn)
    adc_start |-> s_q.meas == GRB_M_WAIT)
    else $error("measurement start outside the wait state");
  AST_STATUS_STICKY: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !(wr_go && wr_idx == `GRB_OFF_IRQ_STAT) |=>
      (s_q.irq_stat & $past(s_q.irq_stat)) == $past(s_q.irq_stat))
    else $error("status bit dropped without a clear");
  // Set beats clear, so an event that meets a clear is never lost
  AST_EVENT_WINS: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ev != 3'b000 |=> (s_q.irq_stat & $past(ev)) == $past(ev))
    else $error("event lost against a status clear");
  AST_RO_PAIR_HELD: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !gauge_load |=> s_q.cell_voltage == $past(s_q.cell_voltage))
    else $error("read-only voltage changed without a gauge load");
  AST_VALID_RESET: assert property (@(posedge aclk)
    $rose(aresetn) |-> s_q.reliable == 5'h00 && !s_q.dbg_sync)
    else $error("validity flags not cleared by reset");
  AST_CTRL_RESET: assert property (@(posedge aclk)
    $rose(aresetn) |->
      s_q.rty_cnt == `GRB_RTY_RST && s_q.meas == GRB_M_IDLE)
    else $error("retry count or sequencer wrong after reset");
  AST_WRITE_ANSWER: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write not answered after both halves");
  AST_SLVERR_WRITE: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (wr_go && !wr_ok) |=> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  AST_READY_TWO_FLOPS: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (!debug_port_ready) [*3] |-> !s_q.dbg_sync)
    else $error("debug ready flag did not fall");
endmodule

// >>> rtl/gauge_regs_defs.svh
// Offsets, field positions, reset values and figures of the gauge readback bank
`ifndef GAUGE_REGS_DEFS_SVH
`define GAUGE_REGS_DEFS_SVH
`define GRB_OFF_VCELL_HI    8'h62
`define GRB_OFF_VCELL_LO    8'h63
`define GRB_OFF_EMPTY_HI    8'h64
`define GRB_OFF_EMPTY_LO    8'h65
`define GRB_OFF_CHARGE_HI   8'h66
`define GRB_OFF_CHARGE_LO   8'h67
`define GRB_OFF_FULL_HI     8'h68
`define GRB_OFF_FULL_LO     8'h69
`define GRB_OFF_VALID       8'h6a
`define GRB_OFF_ADC_CTRL    8'h70
`define GRB_OFF_IRQ_STAT    8'h7c
`define GRB_OFF_IRQ_MASK    8'h7d
`define GRB_OFF_MEAS_CMD    8'h7e
`define GRB_OFF_MEAS_STAT   8'h7f
`define GRB_BIT_DBG_READY   7
`define GRB_BIT_SNIFF_EN    5
`define GRB_VALID_RST       8'h20
`define GRB_THR_MSB         6
`define GRB_THR_LSB         3
`define GRB_RTY_MSB         2
`define GRB_RTY_LSB         0
`define GRB_THR_RST         4'h4
`define GRB_RTY_RST         3'h1
`define GRB_ADC_FULL        8'hff
`define GRB_CLAMP_RST       6'h00
`define GRB_IRQ_DONE        0
`define GRB_IRQ_ABORT       1
`define GRB_IRQ_RETRY       2
`endif

// >>> rtl/grb_pkg.sv
// Types for the gauge readback and resistive ADC retry register bank
package grb_pkg;
  typedef enum logic [1:0] {
    GRB_M_IDLE,
    GRB_M_WAIT,
    GRB_M_JUDGE
  } grb_meas_t;
  typedef enum logic [1:0] {
    GRB_R_NONE,
    GRB_R_GOOD,
    GRB_R_ABORT
  } grb_result_t;
endpackage

// >>> verif/testbench.sv
// Self-checking bench for the gauge readback bank and its ADC retry sequencer
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, adc_start, snif;
  logic [31:0] awaddr, wdata, araddr, rdata, seed;
  logic [3:0]  wstrb, thr_o;
  logic [1:0]  bresp, rresp;
  logic [15:0] gv [4];
  logic        gload, dbg, adone, p1ua;
  logic [4:0]  rel;
  logic [7:0]  pk, av;
  int          err_count, check_count, starts;
  grb_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gauge_cell_voltage(gv[0]),
    .gauge_empty_time(gv[1]), .gauge_charge_level(gv[2]),
    .gauge_full_time(gv[3]), .gauge_load(gload), .gauge_reliable(rel),
    .debug_port_ready(dbg), .adc_done(adone), .adc_peak(pk),
    .adc_average(av), .adc_pullup_1ua(p1ua),
    .noise_clamp_margin(6'h00),
    .adc_start(adc_start), .adc_ground_threshold(thr_o),
    .sniffer_enable(snif), .irq(irq));
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (adc_start === 1'b1) starts++;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected measurement status: result in 5:4, retries used in 2:0
  function automatic logic [7:0] exp_meas(logic [2:0] r, logic [7:0] p,
                                          logic [7:0] a, logic u);
    logic c;
    c = (p == 8'hff) && (!u || a < 8'hff);
    return c ? {4'h2, 1'b0, r} : 8'h10;
  endfunction
  task automatic conclude();
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    awaddr <= {22'h0, i, 2'b00};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    if (n >= 100) tmo();
    // bready stays up between writes; each call sets it to 1 again and none lowers it
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d,
                    output logic [1:0] r);
    int n;
    araddr <= {22'h0, i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    if (n >= 100) tmo();
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic meas(input logic [2:0] rt, input logic [7:0] p, a,
                      input logic u);
    logic [1:0] r;
    logic [7:0] d, e;
    logic [3:0] t;
    int n;
    e = exp_meas(rt, p, a, u);
    t = 4'(xs());
    wr(8'h70, {25'h0, t, rt}, r);
    rd(8'h70, d, r);
    `CHK(d, {1'b0, t, rt})
    repeat (2) @(posedge aclk);
    `CHK(thr_o, t)
    starts = 0;
    wr(8'h7e, 32'h1, r);
    for (int k = 0; k < (e[5] ? rt + 1 : 1); k++) begin
      // The first start pulses alongside bvalid, so count pulses seen
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (starts <= k && n < 50);
      if (starts <= k) tmo();
      @(posedge aclk);
      {adone, pk, av, p1ua} <= {1'b1, p, a, u};
      @(posedge aclk);
      {adone, pk, av} <= {1'b0, 16'(xs())};
    end
    repeat (10) @(posedge aclk);
    `CHK(starts, e[5] ? rt + 1 : 1)
    rd(8'h7f, d, r);
    `CHK(d, e)
    rd(8'h7c, d, r);
    `CHK(d[2:0], {e[5] && rt != 0, e[5], !e[5]})
    `CHK(irq, 1'b1)
    wr(8'h7d, 32'h0, r);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(8'h7d, 32'h7, r);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(8'h7c, 32'h7, r);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, h;
    logic [1:0] r;
    logic [15:0] snap [4];
    seed = 32'h24d4;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {gload, dbg, adone, p1ua, rel, pk, av} = '0;
    for (int i = 0; i < 4; i++) gv[i] = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(snif, 1'b1)
    `CHK(thr_o, 4'h4)
    for (int i = 8'h62; i <= 8'h69; i++) begin
      rd(i[7:0], d, r);
      `CHK({r, d}, 10'h0)
    end
    rd(8'h6a, d, r);
    `CHK(d, 8'h20)
    rd(8'h70, d, r);
    `CHK(d, 8'h21)
    // Gauge snapshots, each pair read back high byte first, from the lower address
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        snap[i] = 16'(xs());
        gv[i] <= snap[i];
      end
      {rel, dbg} <= 6'(xs());
      gload <= 1;
      @(posedge aclk);
      gload <= 0;
      for (int i = 0; i < 4; i++) gv[i] <= 16'(xs());
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
        rd(8'(8'h62 + 2 * i), h, r);
        rd(8'(8'h63 + 2 * i), d, r);
        `CHK({h, d}, snap[i])
      end
      rd(8'h6a, d, r);
      `CHK(d, {dbg, 2'b01, rel})
    end
    wr(8'h62, 32'ha5, r);
    `CHK(r, 2'b00)
    rd(8'h62, d, r);
    `CHK(d, snap[0][15:8])
    wr(8'h6a, 32'hdf, r);
    rd(8'h6a, d, r);
    `CHK(d, {dbg, 2'b00, rel})
    `CHK(snif, 1'b0)
    wr(8'h6a, 32'h20, r);
    rd(8'h50, d, r);
    `CHK(r, 2'b10)
    wr(8'h71, 32'h1, r);
    `CHK(r, 2'b10)
    wr(8'h7d, 32'h7, r);
    meas(3'h1, 8'hff, 8'h10, 1'b0);
    meas(3'h0, 8'hff, 8'h10, 1'b0);
    meas(3'h3, 8'hff, 8'hfe, 1'b1);
    meas(3'h2, 8'hff, 8'hff, 1'b1);
    meas(3'h7, 8'hfe, 8'h00, 1'b0);
    meas(3'h7, 8'hff, 8'h00, 1'b0);
    for (int k = 0; k < 6; k++) begin
      h = 8'(xs());
      meas(h[2:0], h[3] ? 8'hff : h, 8'(xs()), h[4]);
    end
    conclude();
  end
endmodule
